// ---- design/tsl_pkg.sv ----
// package for the trace, condition-code and stack-limit trap unit
// assumes one clock, a synchronous reset and an apb master on the register side
// Overview of operation
// - while trace flag set, raise trace trap after every completed instruction
// - trace flag changes only on vector load or either return instruction
// - other writes to the status word keep the trace flag unchanged
// - condition codes sit in low four status bits, updated from data results
// - address calculations never touch condition codes, only explicit data operations
// - a data write to the status word loads the condition-code bits
// - trap, interrupt and return status loads replace the condition codes
// - condition-code operate sets or clears selected bits, others unchanged
// - each push lowers the stack pointer, which holds the last stored word
// - stack-limit checking guards the kernel stack with a warning trap
// - every kernel-mode stack-pointer store compares its address with the stack limit
// - store address above the limit proceeds without a trap
// - store address at or below the limit is always aborted, and trapped except a yellow one while a yellow response is open
// - violation within sixteen words below limit is a yellow-zone trap
// - yellow trap pushes its two context words normally on the stack
// - red zone ignores the stack pointer, stores context at 0 and 2
// - bus errors in yellow response or kernel stack references become red
// - trace flag is status bit 4, condition codes are bits 3 to 0
// - status bits 15 and 14 give mode; 00 kernel enables the check
package tsl_pkg;
   // apb register offsets
   localparam logic [7:0] TSL_OFS_PSW = 8'h00;
   localparam logic [7:0] TSL_OFS_SL = 8'h04;
   localparam logic [7:0] TSL_OFS_SP = 8'h08;
   localparam logic [7:0] TSL_OFS_STAT = 8'h0C;
   // status word fields
   localparam int TSL_T_BIT = 4;
   localparam int TSL_CC_MSB = 3;
   localparam int TSL_MODE_MSB = 15;
   localparam int TSL_MODE_LSB = 14;
   localparam logic [1:0] TSL_MODE_KERNEL = 2'h0;
   // reset values
   localparam logic [15:0] TSL_PSW_RST = 16'h0000;
   localparam logic [15:0] TSL_SL_RST = 16'h0000;
   localparam logic [15:0] TSL_SP_RST = 16'h0000;
   // stack geometry, in bytes
   localparam logic [15:0] TSL_YELLOW_BYTES = 16'h0020;
   localparam logic [15:0] TSL_SP_STEP = 16'h0002;
   localparam logic [15:0] TSL_RED_ADDR0 = 16'h0000;
   localparam logic [15:0] TSL_RED_ADDR1 = 16'h0002;

   typedef enum logic [3:0] {
      TSL_ST_IDLE = 4'b0001,
      TSL_ST_CTX0 = 4'b0010,
      TSL_ST_CTX1 = 4'b0100,
      TSL_ST_START = 4'b1000
   } tsl_state_e;

   // requests from the instruction sequencer and bus cycle logic
   typedef struct packed {
      logic instr_done;
      logic psw_load_vec;
      logic psw_load_ret;
      logic [15:0] psw_new;
      logic psw_wr;
      logic [15:0] psw_wr_data;
      logic cc_data_op;
      logic [3:0] cc_result;
      logic cc_operate;
      logic cc_set;
      logic [3:0] cc_mask;
      logic sp_push;
      logic sp_store;
      logic [15:0] store_addr;
      logic sp_ref;
      logic bus_err;
      logic trap_done;
      logic ctx_ack;
   } tsl_seq_req_s;

   // answers back to the sequencer
   typedef struct packed {
      logic trace_trap;
      logic yellow_trap;
      logic red_trap;
      logic store_abort;
      logic ctx_store;
      logic [15:0] ctx_addr;
      logic overflow_start;
      logic [15:0] psw;
      logic [15:0] stack_pointer;
   } tsl_seq_rsp_s;

   // merged status word update requests
   typedef struct packed {
      logic load_full;
      logic [15:0] full_val;
      logic wr_word;
      logic [15:0] wr_val;
      logic cc_op;
      logic cc_set;
      logic [3:0] cc_mask;
      logic cc_data;
      logic [3:0] cc_val;
   } tsl_psw_upd_s;
endpackage : tsl_pkg

// ---- design/tsl_psw_reg.sv ----
// processor status word register with its protected fields
// assumes update requests are merged into one struct per cycle, prioritised here
`timescale 1ns/100ps
module tsl_psw_reg (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire tsl_pkg::tsl_psw_upd_s upd,
   output logic [15:0] processor_status_word
);
   import tsl_pkg::*;

   logic [15:0] next_processor_status_word;

   ////////////////////////////////////////////////////////////////////////////
   // next status word, full loads first
   always_comb begin
      next_processor_status_word = processor_status_word;
      if (upd.load_full) begin
         next_processor_status_word = upd.full_val;
      end else if (upd.wr_word) begin
         next_processor_status_word = upd.wr_val;
         // trace flag is protected against plain writes
         next_processor_status_word[TSL_T_BIT] = processor_status_word[TSL_T_BIT];
      end else if (upd.cc_op) begin
         // only the masked codes move
         if (upd.cc_set) begin
            next_processor_status_word[TSL_CC_MSB:0] =
               processor_status_word[TSL_CC_MSB:0] | upd.cc_mask;
         end else begin
            next_processor_status_word[TSL_CC_MSB:0] =
               processor_status_word[TSL_CC_MSB:0] & ~upd.cc_mask;
         end
      end else if (upd.cc_data) begin
         next_processor_status_word[TSL_CC_MSB:0] = upd.cc_val;
      end
   end

   // register only
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         processor_status_word <= TSL_PSW_RST;
      end else if (clk_en) begin
         processor_status_word <= next_processor_status_word;
      end
   end
endmodule : tsl_psw_reg

// ---- design/tsl_limit_cmp.sv ----
// stack limit comparator and zone classifier
// assumes byte addresses, pure combinational path
`timescale 1ns/100ps
module tsl_limit_cmp (
   input wire logic [15:0] store_addr,
   input wire logic [15:0] stack_limit_reg,
   output logic violation,
   output logic red_zone
);
   import tsl_pkg::*;

   logic [15:0] depth;

   // distance below the limit, meaningful only on violation
   always_comb begin
      depth = stack_limit_reg - store_addr;
      violation = (store_addr <= stack_limit_reg);
      red_zone = violation && (depth > TSL_YELLOW_BYTES);
   end
endmodule : tsl_limit_cmp

// ---- design/tsl_trap_unit.sv ----
// trace trap, condition-code and kernel stack-limit trap unit, top level
// assumes the sequencer shares ref_clk and rst; apb slave answers with no wait
`timescale 1ns/100ps
module tsl_trap_unit (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire tsl_pkg::tsl_seq_req_s seq_req,
   output tsl_pkg::tsl_seq_rsp_s seq_rsp
);
   import tsl_pkg::*;

   // apb decode, used by the error path only
   function automatic logic ofs_mapped(input logic [7:0] a);
      ofs_mapped = (a == TSL_OFS_PSW) || (a == TSL_OFS_SL) ||
                   (a == TSL_OFS_SP) || (a == TSL_OFS_STAT);
   endfunction : ofs_mapped

   logic apb_wr;
   logic apb_setup;
   logic [31:0] next_prdata;
   logic [15:0] stack_limit_reg;
   logic [15:0] next_stack_limit_reg;
   logic [15:0] stack_pointer;
   logic [15:0] next_stack_pointer;
   logic [15:0] processor_status_word;
   tsl_psw_upd_s psw_upd;
   tsl_state_e state;
   tsl_state_e next_state;
   logic yellow_busy;
   logic next_yellow_busy;
   logic trace_trap;
   logic next_trace_trap;
   logic yellow_trap;
   logic next_yellow_trap;
   logic red_trap;
   logic next_red_trap;
   logic overflow_start;
   logic next_overflow_start;
   logic violation;
   logic red_zone;
   logic kernel_mode;
   logic checked_store;
   logic red_cause;
   logic yellow_cause;

   ////////////////////////////////////////////////////////////////////////////
   // apb handshake
   always_comb begin
      apb_setup = psel && !penable;
      apb_wr = psel && penable && pwrite;
      pready = 1'b1; // no wait states ever
      pslverr = psel && penable && !ofs_mapped(paddr);
   end

   // read data captured in setup so it is a flop at the access edge
   always_comb begin
      next_prdata = prdata;
      if (apb_setup && !pwrite) begin
         unique case (paddr)
            TSL_OFS_PSW: next_prdata = {16'h0000, processor_status_word};
            TSL_OFS_SL: next_prdata = {16'h0000, stack_limit_reg};
            TSL_OFS_SP: next_prdata = {16'h0000, stack_pointer};
            TSL_OFS_STAT: next_prdata = {25'h0000000, yellow_busy, kernel_mode,
                                         1'b0, state};
            default: next_prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (clk_en) begin
         prdata <= next_prdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stack limit and stack pointer registers
   always_comb begin
      next_stack_limit_reg = stack_limit_reg;
      next_stack_pointer = stack_pointer;
      if (apb_wr && paddr == TSL_OFS_SL) begin
         next_stack_limit_reg = pwdata[15:0];
      end
      // sequencer push beats a software write in the same cycle
      if (seq_req.sp_push) begin
         next_stack_pointer = stack_pointer - TSL_SP_STEP;
      end else if (apb_wr && paddr == TSL_OFS_SP) begin
         next_stack_pointer = pwdata[15:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stack_limit_reg <= TSL_SL_RST;
         stack_pointer <= TSL_SP_RST;
      end else if (clk_en) begin
         stack_limit_reg <= next_stack_limit_reg;
         stack_pointer <= next_stack_pointer;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status word updates, sequencer loads win over software writes
   always_comb begin
      psw_upd.load_full = seq_req.psw_load_vec || seq_req.psw_load_ret;
      psw_upd.full_val = seq_req.psw_new;
      psw_upd.wr_word = seq_req.psw_wr || (apb_wr && paddr == TSL_OFS_PSW);
      psw_upd.wr_val = seq_req.psw_wr ? seq_req.psw_wr_data : pwdata[15:0];
      psw_upd.cc_op = seq_req.cc_operate;
      psw_upd.cc_set = seq_req.cc_set;
      psw_upd.cc_mask = seq_req.cc_mask;
      // address arithmetic never raises cc_data_op
      psw_upd.cc_data = seq_req.cc_data_op;
      psw_upd.cc_val = seq_req.cc_result;
   end

   tsl_psw_reg u_psw (
      .ref_clk(ref_clk),
      .rst(rst),
      .clk_en(clk_en),
      .upd(psw_upd),
      .processor_status_word(processor_status_word)
   );

   ////////////////////////////////////////////////////////////////////////////
   // limit compare on stack stores
   tsl_limit_cmp u_cmp (
      .store_addr(seq_req.store_addr),
      .stack_limit_reg(stack_limit_reg),
      .violation(violation),
      .red_zone(red_zone)
   );

   // trap causes; only kernel stores are checked
   always_comb begin
      kernel_mode = processor_status_word[TSL_MODE_MSB:TSL_MODE_LSB] ==
                    TSL_MODE_KERNEL;
      checked_store = seq_req.sp_store && kernel_mode;
      // errors while the stack may be damaged escalate to red
      red_cause = (checked_store && violation && red_zone) ||
                  (seq_req.bus_err && (yellow_busy ||
                                       (seq_req.sp_ref && kernel_mode)));
      yellow_cause = checked_store && violation && !red_zone && !yellow_busy;
   end

   ////////////////////////////////////////////////////////////////////////////
   // trap pulses and yellow response tracking
   always_comb begin
      next_trace_trap = seq_req.instr_done && processor_status_word[TSL_T_BIT];
      next_yellow_trap = 1'b0;
      next_red_trap = 1'b0;
      next_yellow_busy = yellow_busy;
      if (state == TSL_ST_IDLE) begin
         if (red_cause) begin
            next_red_trap = 1'b1;
            next_yellow_busy = 1'b0;
         end else if (yellow_cause) begin
            // context pushes go through the normal stack path
            next_yellow_trap = 1'b1;
            next_yellow_busy = 1'b1;
         end else if (seq_req.trap_done) begin
            next_yellow_busy = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         trace_trap <= 1'b0;
         yellow_trap <= 1'b0;
         red_trap <= 1'b0;
         yellow_busy <= 1'b0;
      end else if (clk_en) begin
         trace_trap <= next_trace_trap;
         yellow_trap <= next_yellow_trap;
         red_trap <= next_red_trap;
         yellow_busy <= next_yellow_busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // red-zone emergency sequence: two context stores at fixed addresses
   always_comb begin
      next_state = state;
      next_overflow_start = 1'b0;
      unique case (state)
         TSL_ST_IDLE: begin
            if (red_cause) begin
               next_state = TSL_ST_CTX0;
            end
         end
         TSL_ST_CTX0: begin
            if (seq_req.ctx_ack) begin
               next_state = TSL_ST_CTX1;
            end
         end
         TSL_ST_CTX1: begin
            if (seq_req.ctx_ack) begin
               next_state = TSL_ST_START;
            end
         end
         TSL_ST_START: begin
            next_overflow_start = 1'b1;
            next_state = TSL_ST_IDLE;
         end
         default: begin
            next_state = TSL_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= TSL_ST_IDLE;
         overflow_start <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
         overflow_start <= next_overflow_start;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // answers to the sequencer
   always_comb begin
      seq_rsp.trace_trap = trace_trap;
      seq_rsp.yellow_trap = yellow_trap;
      seq_rsp.red_trap = red_trap;
      // abort is combinational so the store never completes
      seq_rsp.store_abort = checked_store && violation;
      seq_rsp.ctx_store = (state == TSL_ST_CTX0) || (state == TSL_ST_CTX1);
      seq_rsp.ctx_addr = (state == TSL_ST_CTX1) ? TSL_RED_ADDR1 : TSL_RED_ADDR0;
      seq_rsp.overflow_start = overflow_start;
      seq_rsp.psw = processor_status_word;
      seq_rsp.stack_pointer = stack_pointer;
   end
endmodule : tsl_trap_unit

// ---- bench/tsl_trap_unit_sva.sv ----
// checker for the trap unit top ports
// assumes a bind from the bench top file
`timescale 1ns/100ps
module tsl_trap_unit_sva (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire tsl_pkg::tsl_seq_req_s seq_req,
   input wire tsl_pkg::tsl_seq_rsp_s seq_rsp
);
   import tsl_pkg::*;
   logic [15:0] lim;
   logic full, pw, quiet, kern;
   logic [3:0] opv;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst || !clk_en);
   ////////////////////////////////////////
   // shadow limit, so aborts can be predicted from ports alone
   always_ff @(posedge ref_clk) begin
      if (rst) lim <= TSL_SL_RST;
      else if (clk_en && psel && penable && pwrite && paddr == TSL_OFS_SL) lim <= pwdata[15:0];
   end
   // update sources, highest priority first
   assign full = seq_req.psw_load_vec | seq_req.psw_load_ret;
   assign pw = seq_req.psw_wr | (psel & penable & pwrite & (paddr == TSL_OFS_PSW));
   assign quiet = !full && !pw && !seq_req.cc_operate;
   assign kern = seq_rsp.psw[15:14] == TSL_MODE_KERNEL;
   assign opv = seq_req.cc_set ? (seq_rsp.psw[3:0] | seq_req.cc_mask)
                               : (seq_rsp.psw[3:0] & ~seq_req.cc_mask);
   ////////////////////////////////////////
   trace_pulse_a: assert property (
      seq_rsp.trace_trap == $past(seq_req.instr_done && seq_rsp.psw[TSL_T_BIT]))
      else $error("trace trap wrong");
   trace_keep_a: assert property (
      !full |=> $stable(seq_rsp.psw[TSL_T_BIT])) else $error("trace flag moved");
   full_load_a: assert property (
      full |=> seq_rsp.psw[4:0] == $past(seq_req.psw_new[4:0])) else $error("load lost");
   cc_write_a: assert property (
      !full && pw |=> seq_rsp.psw[3:0] ==
      $past(seq_req.psw_wr ? seq_req.psw_wr_data[3:0] : pwdata[3:0])) else $error("cc write");
   cc_oper_a: assert property (
      !full && !pw && seq_req.cc_operate |=> seq_rsp.psw[3:0] == $past(opv))
      else $error("cc operate");
   cc_data_a: assert property (
      quiet |=> seq_rsp.psw[3:0] == $past(seq_req.cc_data_op ? seq_req.cc_result
      : seq_rsp.psw[3:0])) else $error("cc data");
   abort_cmp_a: assert property (
      seq_req.sp_store && kern |-> seq_rsp.store_abort == (seq_req.store_addr <= lim))
      else $error("abort wrong");
   red_entry_a: assert property (
      seq_req.sp_store && kern && seq_req.store_addr <= lim && !seq_rsp.ctx_store
      && !$past(seq_rsp.ctx_store) && (lim - seq_req.store_addr > TSL_YELLOW_BYTES)
      |=> seq_rsp.red_trap && seq_rsp.ctx_store && seq_rsp.ctx_addr == TSL_RED_ADDR0)
      else $error("red entry");
   yellow_src_a: assert property (
      seq_rsp.yellow_trap |-> $past(seq_req.sp_store && seq_rsp.store_abort))
      else $error("stray yellow");
   ctx_next_a: assert property (
      seq_rsp.ctx_store && seq_rsp.ctx_addr == TSL_RED_ADDR0 && seq_req.ctx_ack
      |=> seq_rsp.ctx_store && seq_rsp.ctx_addr == TSL_RED_ADDR1) else $error("ctx order");
   ctx_start_a: assert property (
      seq_rsp.ctx_store && seq_rsp.ctx_addr == TSL_RED_ADDR1 && seq_req.ctx_ack
      |=> !seq_rsp.ctx_store ##[0:1] seq_rsp.overflow_start) else $error("no start");
   push_step_a: assert property (
      seq_req.sp_push |=> seq_rsp.stack_pointer == $past(seq_rsp.stack_pointer) - TSL_SP_STEP)
      else $error("push step");
endmodule : tsl_trap_unit_sva

// ---- bench/tsl_seq_model.sv ----
// sequencer stand-in: passes bench requests, answers emergency stores and yellow traps
// assumes ref_clk and rst shared with the trap unit
`timescale 1ns/100ps
module tsl_seq_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire tsl_pkg::tsl_seq_req_s cmd,
   input wire tsl_pkg::tsl_seq_rsp_s seq_rsp,
   output tsl_pkg::tsl_seq_req_s seq_req
);
   import tsl_pkg::*;
   logic ack, done, push;
   int stall, ypend;
   // random stall before each accept after the first, so slow memory is covered too
   always @(posedge ref_clk) begin
      ack <= 1'b0;
      done <= 1'b0;
      push <= 1'b0;
      if (rst) begin
         stall <= 0;
         ypend <= 0;
      end else begin
         if (seq_rsp.ctx_store && !ack) begin
            if (stall == 0) begin
               ack <= 1'b1;
               stall <= $urandom_range(3);
            end else begin
               stall <= stall - 1;
            end
         end
         if (seq_rsp.yellow_trap) begin
            ypend <= 3;
         end else if (ypend != 0) begin
            ypend <= ypend - 1;
            push <= (ypend > 1);
            done <= (ypend == 1);
         end
      end
   end
   // own answers override ctx_ack and trap_done; own pushes are ORed with the bench sp_push
   always_comb begin
      seq_req = cmd;
      seq_req.ctx_ack = ack;
      seq_req.trap_done = done;
      seq_req.sp_push = cmd.sp_push | push;
   end
endmodule : tsl_seq_model

// ---- bench/tsl_trap_unit_tb.sv ----
// bench for the trap unit: apb access plus sequencer traffic
// assumes tsl_seq_model on the far side; clk_en held high
`timescale 1ns/100ps
module tsl_trap_unit_tb;
   import tsl_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   tsl_seq_req_s cmd = '0, seq_req, v;
   tsl_seq_rsp_s seq_rsp;
   logic [15:0] lim, a, sp;
   logic [15:0] corner [4] = '{16'h0100, 16'h00E0, 16'h00DE, 16'h0102};
   logic [3:0] cc;
   int failures = 0, total_checks = 0, n;
   always #50 ref_clk = ~ref_clk;
   tsl_trap_unit u_tsl_trap_unit (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_req(seq_req),
      .seq_rsp(seq_rsp));
   tsl_seq_model u_tsl_seq_model (.ref_clk(ref_clk), .rst(rst), .cmd(cmd),
      .seq_rsp(seq_rsp), .seq_req(seq_req));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one apb transfer; holds until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   task automatic pulse(input tsl_seq_req_s r);
      @(posedge ref_clk);
      cmd <= r;
      @(posedge ref_clk);
      cmd <= '0;
      #1;
   endtask : pulse
   function automatic logic [1:0] zone(input logic [15:0] ad, input logic [15:0] l);
      if (ad > l) return 2'h0;
      return (l - ad > TSL_YELLOW_BYTES) ? 2'h2 : 2'h1;
   endfunction : zone
   // wait out the trap response, then check where the pointer ended
   task automatic settle(input logic [1:0] z);
      int k;
      k = 0;
      while (k < 40 && ((z == 2'h2 && seq_rsp.overflow_start !== 1'b1)
             || (z == 2'h1 && seq_req.trap_done !== 1'b1))) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      if (z == 2'h2) chk(32'(seq_rsp.overflow_start), 32'h1);
      if (z == 2'h1) sp = sp - 16'h0004;
      @(posedge ref_clk);
      #1;
      chk(32'(seq_rsp.stack_pointer), 32'(sp));
   endtask : settle
   task automatic store(input logic [15:0] ad, input logic [1:0] z, input logic b, h);
      tsl_seq_req_s r;
      r = '0;
      r.sp_store = 1'b1;
      r.store_addr = ad;
      @(posedge ref_clk);
      cmd <= r;
      #1;
      chk(32'(seq_rsp.store_abort), 32'(z != 2'h0));
      @(posedge ref_clk);
      cmd <= '0;
      #1;
      chk(32'({seq_rsp.yellow_trap, seq_rsp.red_trap}), 32'({z == 1 && !b, z == 2}));
      if (!h) settle(z);
   endtask : store
   task automatic end_sim();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////
   initial begin
      void'($urandom(62));
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      // reset values, status register, unmapped offset
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk(q, (i == 3) ? 32'h21 : 32'h0);
         chk(32'(e), 32'(i == 4));
      end
      $display("reset test done");
      v = '0;
      v.psw_load_vec = 1'b1;
      v.psw_new = 16'h0010 | (16'($urandom()) & 16'h000F);
      pulse(v);
      chk(32'(seq_rsp.psw), 32'(v.psw_new));
      v = '0;
      v.instr_done = 1'b1;
      pulse(v);
      chk(32'(seq_rsp.trace_trap), 32'h1);
      v = '0;
      v.psw_wr = 1'b1;
      v.psw_wr_data = 16'($urandom()) & 16'h000F;
      pulse(v);
      chk(32'(seq_rsp.psw[4:0]), 32'({1'b1, v.psw_wr_data[3:0]}));
      apb(1'b1, TSL_OFS_PSW, 32'h0);
      chk(32'(seq_rsp.psw[4:0]), 32'h10);
      v = '0;
      v.psw_load_ret = 1'b1;
      v.psw_new = 16'h0005;
      pulse(v);
      chk(32'(seq_rsp.psw), 32'h5);
      v = '0;
      v.instr_done = 1'b1;
      pulse(v);
      chk(32'(seq_rsp.trace_trap), 32'h0);
      $display("trace test done");
      cc = 4'h5;
      sp = TSL_SP_RST;
      for (int i = 0; i < 24; i++) begin
         v = '0;
         v.cc_mask = 4'($urandom());
         v.cc_set = 1'($urandom());
         v.cc_result = 4'($urandom());
         n = $urandom_range(2);
         v.cc_operate = (n == 0);
         v.cc_data_op = (n == 1);
         v.sp_push = (n == 2);
         if (n == 0) cc = v.cc_set ? (cc | v.cc_mask) : (cc & ~v.cc_mask);
         if (n == 1) cc = v.cc_result;
         if (n == 2) sp = sp - TSL_SP_STEP;
         pulse(v);
         chk(32'(seq_rsp.psw[3:0]), 32'(cc));
         chk(32'(seq_rsp.stack_pointer), 32'(sp));
      end
      $display("condition code test done");
      lim = 16'h0100;
      sp = 16'h0200;
      apb(1'b1, TSL_OFS_SL, 32'(lim));
      apb(1'b1, TSL_OFS_SP, 32'(sp));
      // corners first: at the limit, yellow edge, first red, just above
      for (int i = 0; i < 14; i++) begin
         a = (i < 4) ? corner[i] : lim - 16'h0040 + 16'($urandom_range(72));
         store(a, zone(a, lim), 1'b0, 1'b0);
      end
      // second violation while the yellow response is still open
      store(16'h00F0, 2'h1, 1'b0, 1'b1);
      store(16'h00F8, 2'h1, 1'b1, 1'b0);
      v = '0;
      v.sp_ref = 1'b1;
      v.bus_err = 1'b1;
      pulse(v);
      chk(32'(seq_rsp.red_trap), 32'h1);
      settle(2'h2);
      v = '0;
      v.psw_load_vec = 1'b1;
      v.psw_new = 16'hC000;
      pulse(v);
      store(lim, 2'h0, 1'b0, 1'b0);
      $display("stack limit test done");
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      end_sim();
   end
endmodule : tsl_trap_unit_tb
bind tsl_trap_unit tsl_trap_unit_sva u_tsl_trap_unit_sva (.ref_clk(ref_clk), .rst(rst),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .seq_req(seq_req), .seq_rsp(seq_rsp));
